// file: hdl/usbic_defs.svh
// Register offsets, field positions and reset values of the endpoint 1 IN control block.
`ifndef USBIC_DEFS_SVH
`define USBIC_DEFS_SVH
`define USBIC_ADDR_CTRL_LOW 8'h11
`define USBIC_ADDR_CTRL_HIGH 8'h12
`define USBIC_ADDR_INT_STATUS 8'h13
`define USBIC_ADDR_INT_MASK 8'h14
`define USBIC_ADDR_ISO_UPDATE 8'h15
`define USBIC_LOW_IN_PACKET_READY 0
`define USBIC_LOW_FIFO_NONEMPTY 1
`define USBIC_LOW_UNDERRUN 2
`define USBIC_LOW_FLUSH 3
`define USBIC_LOW_SEND_STALL 4
`define USBIC_LOW_STALL_SENT 5
`define USBIC_LOW_TOGGLE_CLEAR 6
`define USBIC_HIGH_FORCE_TOGGLE 3
`define USBIC_HIGH_ISO 6
`define USBIC_HIGH_DOUBLE_BUFFER 7
`define USBIC_INT_TX 0
`define USBIC_INT_FLUSH 1
`define USBIC_INT_STALL 2
`define USBIC_RESET_BYTE 8'h00
`define USBIC_RESET_CNT 2'h0
`define USBIC_RESET_INT 3'h0
`endif

// file: hdl/usbic_pkg.sv
// Types shared by the endpoint 1 IN control block.
package usbic_pkg;
  typedef enum logic [0:0] {
    USBIC_IDLE = 1'b0,
    USBIC_WAIT_ACK = 1'b1
  } usbic_state_t;
  typedef struct packed {
    logic [1:0] ready;
    logic [1:0] held;
  } usbic_slot_state_t;
  typedef struct packed {
    logic [2:0] status;
    logic [2:0] mask;
  } usbic_irq_state_t;
endpackage

// file: hdl/usbic_slots.sv
// Packet slot bookkeeping with the hold-until-start-of-frame option.
`include "usbic_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module usbic_slots (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic commit,
  input wire logic take,
  input wire logic flush,
  input wire logic sof,
  input wire logic hold_mode,
  input wire logic [1:0] capacity,
  output logic [1:0] ready_cnt,
  output logic [1:0] total_cnt
);
  usbic_pkg::usbic_slot_state_t s_r;
  usbic_pkg::usbic_slot_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (take && s_nxt.ready != 2'h0) begin
      s_nxt.ready = s_nxt.ready - 2'h1;
    end
    if (flush) begin
      if (s_nxt.ready != 2'h0) begin
        s_nxt.ready = s_nxt.ready - 2'h1;
      end else if (s_nxt.held != 2'h0) begin
        s_nxt.held = s_nxt.held - 2'h1;
      end
    end
    if (sof) begin
      s_nxt.ready = s_nxt.ready + s_nxt.held;
      s_nxt.held = 2'h0;
    end
    if (commit && (s_r.ready + s_r.held) < capacity) begin
      if (hold_mode) begin
        s_nxt.held = s_nxt.held + 2'h1;
      end else begin
        s_nxt.ready = s_nxt.ready + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= {`USBIC_RESET_CNT, `USBIC_RESET_CNT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ready_cnt = s_r.ready;
  assign total_cnt = s_r.ready + s_r.held;

  a_hold_until_sof: assert property (@(posedge clk) disable iff (!rst_n)
    commit && hold_mode && !sof && !take && !flush && total_cnt < capacity
    |=> ready_cnt == $past(ready_cnt) && s_r.held == $past(s_r.held) + 2'h1)
    else $error("Held packet became ready before start of frame.");
endmodule // usbic_slots
`default_nettype wire

// file: hdl/usbic_irq.sv
// Sticky interrupt status with mask and write-one-to-clear.
`include "usbic_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module usbic_irq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] events,
  input wire logic wr_status,
  input wire logic wr_mask,
  input wire logic [2:0] wdata,
  output logic [2:0] status,
  output logic [2:0] mask,
  output logic irq
);
  usbic_pkg::usbic_irq_state_t s_r;
  usbic_pkg::usbic_irq_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (wr_status) begin
      s_nxt.status = s_nxt.status & ~wdata;
    end
    s_nxt.status = s_nxt.status | events;
    if (wr_mask) begin
      s_nxt.mask = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= {`USBIC_RESET_INT, `USBIC_RESET_INT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign status = s_r.status;
  assign mask = s_r.mask;
  assign irq = |(s_r.status & s_r.mask);
endmodule // usbic_irq
`default_nettype wire

// file: hdl/usbic_ep1_in.sv
// Endpoint 1 IN control logic: registers, token answers, toggle and interrupts.
// Summary of operation
// - Isochronous select bit chooses bulk/interrupt (0) or isochronous (1).
// - Packet-ready clears automatically once a FIFO packet slot is free.
// - Double buffered: packet-ready clears right after first load, no interrupt.
// - Transmit interrupt only when a data packet is actually sent.
// - Isochronous token with no ready packet sends zero-length packet, sets underrun.
// - Held-update mode sends a newly loaded packet only after next SOF.
// - Send-stall request set answers every IN token with STALL.
// - Each STALL sets stall-sent and interrupts; firmware clears the flag.
// - Flush write with non-empty FIFO raises an endpoint interrupt.
// - Force toggle or isochronous select flips after every data packet, not after zero-length ones; otherwise only on ACK.
//
// Strobed register access is this design's own decision.
`include "usbic_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module usbic_ep1_in (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic in_token,
  input wire logic sof,
  input wire logic ack_rcvd,
  output logic tx_data,
  output logic tx_zero_length,
  output logic tx_stall,
  output logic tx_nak,
  output logic fifo_flush,
  output logic data_toggle,
  output logic irq
);
  typedef struct packed {
    usbic_pkg::usbic_state_t state;
    logic [7:0] rdata;
    logic in_packet_ready;
    logic underrun_flag;
    logic stall_sent_flag;
    logic send_stall_request;
    logic double_buffer_enable;
    logic iso_enable;
    logic force_toggle_enable;
    logic iso_update;
    logic toggle;
    logic tx_data;
    logic tx_zlp;
    logic tx_stall;
    logic tx_nak;
    logic flush;
  } usbic_main_t;

  usbic_main_t s_r;
  usbic_main_t s_nxt;

  logic wr_low;
  logic wr_high;
  logic wr_status;
  logic wr_mask;
  logic wr_upd;
  logic commit;
  logic flush_req;
  logic toggle_clear;
  logic take;
  logic [1:0] capacity;
  logic [1:0] ready_cnt;
  logic [1:0] total_cnt;
  logic fifo_nonempty_flag;
  logic [2:0] events;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  logic [7:0] low_view;
  logic [7:0] high_view;

  assign wr_low = reg_wr && reg_addr == `USBIC_ADDR_CTRL_LOW;
  assign wr_high = reg_wr && reg_addr == `USBIC_ADDR_CTRL_HIGH;
  assign wr_status = reg_wr && reg_addr == `USBIC_ADDR_INT_STATUS;
  assign wr_mask = reg_wr && reg_addr == `USBIC_ADDR_INT_MASK;
  assign wr_upd = reg_wr && reg_addr == `USBIC_ADDR_ISO_UPDATE;
  assign commit = wr_low && reg_wdata[`USBIC_LOW_IN_PACKET_READY];
  assign flush_req = wr_low && reg_wdata[`USBIC_LOW_FLUSH];
  assign toggle_clear = wr_low && reg_wdata[`USBIC_LOW_TOGGLE_CLEAR];
  assign capacity = s_r.double_buffer_enable ? 2'h2 : 2'h1;
  assign fifo_nonempty_flag = total_cnt != 2'h0;

  // A data packet goes out only when no stall is requested and one is ready.
  assign take = in_token && !s_r.send_stall_request && ready_cnt != 2'h0;

  always_comb begin
    events = 3'h0;
    events[`USBIC_INT_TX] = take;
    events[`USBIC_INT_FLUSH] = flush_req && fifo_nonempty_flag;
    events[`USBIC_INT_STALL] = in_token && s_r.send_stall_request;
  end

  usbic_slots u_slots (
    .clk(clk),
    .rst_n(rst_n),
    .commit(commit),
    .take(take),
    .flush(flush_req),
    .sof(sof),
    .hold_mode(s_r.iso_update),
    .capacity(capacity),
    .ready_cnt(ready_cnt),
    .total_cnt(total_cnt)
  );

  usbic_irq u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .events(events),
    .wr_status(wr_status),
    .wr_mask(wr_mask),
    .wdata(reg_wdata[2:0]),
    .status(int_status),
    .mask(int_mask),
    .irq(irq)
  );

  always_comb begin
    low_view = 8'h00;
    low_view[`USBIC_LOW_IN_PACKET_READY] = s_r.in_packet_ready;
    low_view[`USBIC_LOW_FIFO_NONEMPTY] = fifo_nonempty_flag;
    low_view[`USBIC_LOW_UNDERRUN] = s_r.underrun_flag;
    low_view[`USBIC_LOW_SEND_STALL] = s_r.send_stall_request;
    low_view[`USBIC_LOW_STALL_SENT] = s_r.stall_sent_flag;
    high_view = 8'h00;
    high_view[`USBIC_HIGH_DOUBLE_BUFFER] = s_r.double_buffer_enable;
    high_view[`USBIC_HIGH_ISO] = s_r.iso_enable;
    high_view[`USBIC_HIGH_FORCE_TOGGLE] = s_r.force_toggle_enable;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.tx_data = 1'b0;
    s_nxt.tx_zlp = 1'b0;
    s_nxt.tx_stall = 1'b0;
    s_nxt.tx_nak = 1'b0;
    s_nxt.flush = flush_req;
    // Read data stand in the cycle after the strobe only.
    s_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `USBIC_ADDR_CTRL_LOW: begin
          s_nxt.rdata = low_view;
        end
        `USBIC_ADDR_CTRL_HIGH: begin
          s_nxt.rdata = high_view;
        end
        `USBIC_ADDR_INT_STATUS: begin
          s_nxt.rdata = {5'h00, int_status};
        end
        `USBIC_ADDR_INT_MASK: begin
          s_nxt.rdata = {5'h00, int_mask};
        end
        `USBIC_ADDR_ISO_UPDATE: begin
          s_nxt.rdata = {7'h00, s_r.iso_update};
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end
    // Firmware writes; flags written zero clear, a set below still wins.
    if (wr_low) begin
      s_nxt.send_stall_request = reg_wdata[`USBIC_LOW_SEND_STALL];
      s_nxt.stall_sent_flag = s_r.stall_sent_flag && reg_wdata[`USBIC_LOW_STALL_SENT];
      s_nxt.underrun_flag = s_r.underrun_flag && reg_wdata[`USBIC_LOW_UNDERRUN];
    end
    if (wr_high) begin
      s_nxt.double_buffer_enable = reg_wdata[`USBIC_HIGH_DOUBLE_BUFFER];
      s_nxt.iso_enable = reg_wdata[`USBIC_HIGH_ISO];
      s_nxt.force_toggle_enable = reg_wdata[`USBIC_HIGH_FORCE_TOGGLE];
    end
    if (wr_upd) begin
      s_nxt.iso_update = reg_wdata[0];
    end
    // Packet-ready clears as soon as a slot is free again, with no interrupt.
    if (s_r.in_packet_ready && total_cnt < capacity) begin
      s_nxt.in_packet_ready = 1'b0;
    end
    if (flush_req) begin
      s_nxt.in_packet_ready = 1'b0;
    end
    if (commit) begin
      s_nxt.in_packet_ready = 1'b1;
    end
    // Token answer, one cycle after the token.
    if (in_token) begin
      s_nxt.state = usbic_pkg::USBIC_IDLE;
      if (s_r.send_stall_request) begin
        s_nxt.tx_stall = 1'b1;
        s_nxt.stall_sent_flag = 1'b1;
      end else if (take) begin
        s_nxt.tx_data = 1'b1;
        if (s_r.force_toggle_enable || s_r.iso_enable) begin
          s_nxt.toggle = !s_r.toggle;
        end else begin
          s_nxt.state = usbic_pkg::USBIC_WAIT_ACK;
        end
      end else if (s_r.iso_enable) begin
        s_nxt.tx_zlp = 1'b1;
        s_nxt.underrun_flag = 1'b1;
      end else begin
        s_nxt.tx_nak = 1'b1;
        s_nxt.underrun_flag = 1'b1;
      end
    end
    case (s_r.state)
      usbic_pkg::USBIC_IDLE: begin
      end
      usbic_pkg::USBIC_WAIT_ACK: begin
        if (ack_rcvd && !in_token) begin
          s_nxt.toggle = !s_r.toggle;
          s_nxt.state = usbic_pkg::USBIC_IDLE;
        end
      end
      default: begin
        s_nxt.state = usbic_pkg::USBIC_IDLE;
      end
    endcase
    if (toggle_clear) begin
      s_nxt.toggle = 1'b0;
      s_nxt.state = usbic_pkg::USBIC_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign tx_data = s_r.tx_data;
  assign tx_zero_length = s_r.tx_zlp;
  assign tx_stall = s_r.tx_stall;
  assign tx_nak = s_r.tx_nak;
  assign fifo_flush = s_r.flush;
  assign data_toggle = s_r.toggle;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_iso_mode_select: assert property (
    in_token && !s_r.send_stall_request && ready_cnt == 2'h0
    |=> tx_zero_length == $past(s_r.iso_enable) && tx_nak == !$past(s_r.iso_enable))
    else $error("Empty-FIFO answer does not follow the isochronous select.");

  a_ready_slot_free: assert property (
    s_r.in_packet_ready && total_cnt < capacity && !commit |=> !s_r.in_packet_ready)
    else $error("Packet-ready stayed set with a free slot.");

  a_double_buf_clear: assert property (
    commit && s_r.double_buffer_enable && total_cnt == 2'h0 && !wr_high
    ##1 !commit && !in_token && !wr_status
    |=> !s_r.in_packet_ready && int_status[`USBIC_INT_TX] == $past(int_status[`USBIC_INT_TX], 2))
    else $error("Double-buffered load did not clear packet-ready quietly.");

  a_tx_event_only: assert property (
    $rose(int_status[`USBIC_INT_TX]) |-> $past(take) && tx_data)
    else $error("Transmit interrupt without a transmitted packet.");

  a_zlp_underrun: assert property (
    in_token && s_r.iso_enable && !s_r.send_stall_request && ready_cnt == 2'h0
    |=> tx_zero_length && s_r.underrun_flag && !tx_data)
    else $error("Isochronous underrun not answered with zero-length packet.");

  a_stall_answer: assert property (
    in_token && s_r.send_stall_request |=> tx_stall && !tx_data && !tx_zero_length && !tx_nak)
    else $error("Stall request not answered with STALL.");

  a_stall_flag: assert property (
    tx_stall |-> s_r.stall_sent_flag && int_status[`USBIC_INT_STALL])
    else $error("STALL sent without flag and interrupt.");

  a_flush_irq: assert property (
    flush_req && fifo_nonempty_flag |=> int_status[`USBIC_INT_FLUSH] && fifo_flush)
    else $error("Flush of non-empty FIFO raised no interrupt.");

  a_force_toggle: assert property (
    take && s_r.force_toggle_enable && !toggle_clear |=> data_toggle != $past(data_toggle))
    else $error("Forced toggle did not flip after a packet.");

  a_toggle_clear: assert property (
    toggle_clear |=> !data_toggle)
    else $error("Toggle clear did not return to DATA0.");

  a_underrun_sticky: assert property (
    s_r.underrun_flag && !(wr_low && !reg_wdata[`USBIC_LOW_UNDERRUN]) |=> s_r.underrun_flag)
    else $error("Underrun flag dropped without a zero write.");

  a_stall_sent_sticky: assert property (
    s_r.stall_sent_flag && !(wr_low && !reg_wdata[`USBIC_LOW_STALL_SENT]) |=> s_r.stall_sent_flag)
    else $error("Stall-sent flag dropped without a zero write.");

  a_commit_sets_ready: assert property (
    commit |=> s_r.in_packet_ready)
    else $error("Packet-ready not set by a packet load.");

  a_slot_free_quiet: assert property (
    s_r.in_packet_ready && total_cnt < capacity && !take && !wr_status
    |=> int_status[`USBIC_INT_TX] == $past(int_status[`USBIC_INT_TX]))
    else $error("Freeing a slot raised a transmit interrupt.");

  a_tx_data_packet: assert property (
    take |=> tx_data && int_status[`USBIC_INT_TX])
    else $error("Sent packet without transmit interrupt.");

  a_one_answer: assert property (
    in_token |=> $onehot({tx_stall, tx_data, tx_zero_length, tx_nak}))
    else $error("Token not answered by exactly one reply.");

  a_no_token_quiet: assert property (
    !in_token |=> !tx_data && !tx_stall && !tx_zero_length && !tx_nak)
    else $error("Reply sent without a token.");

  a_nak_underrun: assert property (
    in_token && !s_r.iso_enable && !s_r.send_stall_request && ready_cnt == 2'h0
    |=> tx_nak && s_r.underrun_flag)
    else $error("Bulk NAK did not set the underrun flag.");

  a_ack_toggle: assert property (
    s_r.state == usbic_pkg::USBIC_WAIT_ACK && ack_rcvd && !in_token && !toggle_clear
    |=> data_toggle != $past(data_toggle))
    else $error("ACK did not flip the data toggle.");

  a_no_ack_hold: assert property (
    take && !s_r.force_toggle_enable && !s_r.iso_enable && !toggle_clear
    |=> data_toggle == $past(data_toggle))
    else $error("Toggle flipped before the ACK.");

  a_clear_reads_zero: assert property (
    reg_rd && reg_addr == `USBIC_ADDR_CTRL_LOW
    |=> !reg_rdata[`USBIC_LOW_TOGGLE_CLEAR] && !reg_rdata[`USBIC_LOW_FLUSH])
    else $error("Write-only control bits read back as one.");
endmodule // usbic_ep1_in
`default_nettype wire

// file: sim/usbic_host_model.sv
// Host model that issues IN tokens, start-of-frame marks and ACK handshakes.
`timescale 1ns/10ps
`default_nettype none
module usbic_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_data,
  input wire logic ack_on,
  output logic in_token,
  output logic sof,
  output logic ack_rcvd
);
  initial begin
    in_token = 1'b0;
    sof = 1'b0;
  end
  // Sends one IN token; isochronous runs call it once per frame.
  task automatic token();
    in_token <= 1'b1;
    @(posedge clk);
    in_token <= 1'b0;
  endtask
  // Marks the start of a new frame.
  task automatic frame();
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
  endtask
  // Answers a sent data packet with an ACK when enabled.
  always @(posedge clk) begin
    ack_rcvd <= rst_n & ack_on & tx_data;
  end
endmodule // usbic_host_model
`default_nettype wire

// file: sim/usb_ep1_in_iso_control_bench.sv
// Self-checking bench of the endpoint 1 IN control block.
`timescale 1ns/10ps
`default_nettype none
module usb_ep1_in_iso_control_bench;
  logic clk, rst_n, reg_wr, reg_rd, tx_data, tx_zero_length, tx_stall, tx_nak;
  logic fifo_flush, data_toggle, irq, in_token, sof, ack_rcvd, ack_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int miscompares, checks_done;
  usbic_ep1_in dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_token(in_token),
    .sof(sof), .ack_rcvd(ack_rcvd), .tx_data(tx_data), .tx_zero_length(tx_zero_length),
    .tx_stall(tx_stall), .tx_nak(tx_nak), .fifo_flush(fifo_flush),
    .data_toggle(data_toggle), .irq(irq));
  usbic_host_model host (.clk(clk), .rst_n(rst_n), .tx_data(tx_data), .ack_on(ack_on),
    .in_token(in_token), .sof(sof), .ack_rcvd(ack_rcvd));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
    @(posedge clk);
  endtask
  task automatic tok(input logic [3:0] e);
    host.token();
    #1;
    chk("answer", {4'h0, e}, {4'h0, tx_stall, tx_data, tx_zero_length, tx_nak});
    repeat (4) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h30, 8'h00);
  endtask
  task automatic t_bulk();
    wr(8'h14, 8'h07);
    tok(4'h1);
    rd(8'h11, 8'h04);
    wr(8'h11, 8'h00);
    rd(8'h11, 8'h00);
    wr(8'h11, 8'h01);
    rd(8'h11, 8'h03);
    ack_on <= 1'b1;
    tok(4'h4);
    chk("toggle", 8'h01, {7'h00, data_toggle});
    rd(8'h11, 8'h00);
    rd(8'h13, 8'h01);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    wr(8'h13, 8'h07);
    #1;
    chk("irq", 8'h00, {7'h00, irq});
  endtask
  task automatic t_toggle();
    wr(8'h11, 8'h40);
    #1;
    chk("toggle", 8'h00, {7'h00, data_toggle});
    rd(8'h11, 8'h00);
    ack_on <= 1'b0;
    wr(8'h12, 8'h08);
    wr(8'h11, 8'h01);
    tok(4'h4);
    chk("toggle", 8'h01, {7'h00, data_toggle});
    wr(8'h12, 8'h00);
    wr(8'h11, 8'h01);
    tok(4'h4);
    tok(4'h1);
    chk("toggle", 8'h01, {7'h00, data_toggle});
    wr(8'h11, 8'h00);
    wr(8'h13, 8'h07);
  endtask
  task automatic t_iso();
    wr(8'h12, 8'h40);
    host.frame();
    tok(4'h2);
    rd(8'h11, 8'h04);
    wr(8'h11, 8'h00);
    wr(8'h13, 8'h07);
  endtask
  task automatic t_double();
    wr(8'h12, 8'hC0);
    wr(8'h11, 8'h01);
    rd(8'h11, 8'h02);
    rd(8'h13, 8'h00);
    wr(8'h11, 8'h01);
    rd(8'h11, 8'h03);
    host.frame();
    tok(4'h4);
    rd(8'h11, 8'h02);
    host.frame();
    tok(4'h4);
    rd(8'h11, 8'h00);
    rd(8'h13, 8'h01);
    wr(8'h13, 8'h07);
  endtask
  task automatic t_hold();
    wr(8'h12, 8'h40);
    wr(8'h15, 8'h01);
    rd(8'h15, 8'h01);
    host.frame();
    wr(8'h11, 8'h01);
    tok(4'h2);
    host.frame();
    tok(4'h4);
    wr(8'h15, 8'h00);
    wr(8'h11, 8'h00);
    wr(8'h13, 8'h07);
  endtask
  task automatic t_stall();
    wr(8'h12, 8'h00);
    wr(8'h11, 8'h10);
    tok(4'h8);
    tok(4'h8);
    rd(8'h11, 8'h30);
    rd(8'h13, 8'h04);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    wr(8'h14, 8'h03);
    #1;
    chk("irq", 8'h00, {7'h00, irq});
    wr(8'h14, 8'h07);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    wr(8'h11, 8'h00);
    rd(8'h11, 8'h00);
    wr(8'h13, 8'h07);
  endtask
  task automatic t_flush();
    wr(8'h11, 8'h01);
    reg_addr <= 8'h11;
    reg_wdata <= 8'h08;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    chk("fifo_flush", 8'h01, {7'h00, fifo_flush});
    @(posedge clk);
    rd(8'h13, 8'h02);
    rd(8'h11, 8'h00);
    wr(8'h13, 8'h07);
    wr(8'h11, 8'h08);
    rd(8'h13, 8'h00);
  endtask
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ack_on = 1'b0;
    miscompares = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_bulk();
    t_toggle();
    t_iso();
    t_double();
    t_hold();
    t_stall();
    t_flush();
    stop_test();
  end
endmodule // usb_ep1_in_iso_control_bench
`default_nettype wire
